// file: hybrid_trng_pkg.sv
// constants for the hybrid physical random generator
// assumes a single 100 MHz clock and a raw source bit stream
package hybrid_trng_pkg;

    localparam int CLK_PERIOD_NS = 10;

    // total failure: identical-bit run and silent-source limits
    localparam int TF_RUN_LIMIT   = 32;
    localparam int SILENCE_NS     = 10000;
    localparam int SILENCE_CYCLES = (SILENCE_NS / CLK_PERIOD_NS < 1) ? 1 : SILENCE_NS / CLK_PERIOD_NS;

    // online proportion test over a window of raw bits
    localparam int WIN_LEN = 64;
    localparam int ONES_LO = 20;
    localparam int ONES_HI = 44;

    // raw bits absorbed before the first word may leave
    localparam int SEED_BITS = 256;

    // output word widths
    localparam int W8  = 8;
    localparam int W16 = 16;

    // post-processor geometry and domain tweaks
    localparam int          CHUNK_BITS  = 32;
    localparam int          CREDIT_BITS = 16;
    localparam logic [127:0] EMIT_TWEAK = 128'h0000_0000_0000_0000_0000_0000_5A5A_0001;
    localparam logic [127:0] OUT_TWEAK  = 128'hC3C3_0000_0000_0000_0000_0000_0000_0002;
    localparam logic [127:0] STATE_INIT = 128'h6170_7865_3320_646E_7962_2D32_6B20_6574;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_STARTUP = 6'h02,
        ST_SEED    = 6'h04,
        ST_RUN     = 6'h08,
        ST_DEFECT  = 6'h10,
        ST_FAIL    = 6'h20
    } gen_state_type;

endpackage : hybrid_trng_pkg

// file: hybrid_physical_generator.sv
// hybrid physical random generator: health tests, seeding, cryptographic post-processing
// assumes raw_bit_i/raw_valid_i synchronous to clk_i from an on-chip entropy source
`timescale 1ns/1ns

module hybrid_physical_generator #(
    parameter int TF_RUN    = hybrid_trng_pkg::TF_RUN_LIMIT,
    parameter int SEED_BITS = hybrid_trng_pkg::SEED_BITS
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // control
    input  wire logic        start_i,
    input  wire logic        width16_i,
    // raw entropy source
    input  wire logic        raw_bit_i,
    input  wire logic        raw_valid_i,
    // random word stream
    output logic [15:0]      rnd_data_o,
    output logic             rnd_valid_o,
    input  wire logic        rnd_ready_i,
    // status
    output logic             total_fail_o,
    output logic             defect_o,
    output logic             seeded_o
);

    localparam int RUN_W  = $clog2(TF_RUN + 1);
    localparam int SIL_W  = $clog2(hybrid_trng_pkg::SILENCE_CYCLES + 1);
    localparam int WIN_W  = $clog2(hybrid_trng_pkg::WIN_LEN + 1);
    localparam int SEED_W = $clog2(SEED_BITS + 1);
    localparam int CRW    = hybrid_trng_pkg::CREDIT_BITS;
    localparam int CHW    = $clog2(hybrid_trng_pkg::CHUNK_BITS);
    localparam int DLW    = $clog2(TF_RUN + 1);

    if (TF_RUN < 2 || SEED_BITS < hybrid_trng_pkg::CHUNK_BITS)
    begin : g_bad_params
        $error("hybrid_physical_generator: unsupported parameter values");
    end

    // quarter-round rotate and mix
    function automatic logic [31:0] rotl(input logic [31:0] x, input int n);
        rotl = (x << n) | (x >> (32 - n));
    endfunction : rotl

    function automatic logic [127:0] qround(input logic [127:0] s);
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [31:0] d;
        a = s[127:96];
        b = s[95:64];
        c = s[63:32];
        d = s[31:0];
        a = a + b;
        d = rotl(d ^ a, 16);
        c = c + d;
        b = rotl(b ^ c, 12);
        a = a + b;
        d = rotl(d ^ a, 8);
        c = c + d;
        b = rotl(b ^ c, 7);
        qround = {a, b, c, d};
    endfunction : qround

    function automatic logic [15:0] out_func(input logic [127:0] s);
        logic [127:0] t;
        t = qround(qround(s ^ hybrid_trng_pkg::OUT_TWEAK)) ^ s;
        out_func = t[15:0] ^ t[79:64];
    endfunction : out_func

    // state
    hybrid_trng_pkg::gen_state_type state_reg, state_next;
    logic              last_bit_reg, last_bit_next;
    logic [RUN_W-1:0]  run_len_reg, run_len_next;
    logic [SIL_W-1:0]  silence_reg, silence_next;
    logic [WIN_W-1:0]  win_cnt_reg, win_cnt_next;
    logic [WIN_W-1:0]  ones_reg, ones_next;
    logic [TF_RUN-1:0] delay_reg, delay_next;
    logic [DLW-1:0]    fill_reg, fill_next;
    logic [31:0]       chunk_reg, chunk_next;
    logic [CHW-1:0]    chunk_cnt_reg, chunk_cnt_next;
    logic [SEED_W-1:0] seed_cnt_reg, seed_cnt_next;
    logic [CRW-1:0]    credit_reg, credit_next;
    logic [127:0]      pp_state_reg, pp_state_next;
    logic [15:0]       out_word_reg, out_word_next;

    logic              active;
    logic              same_bit;
    logic [WIN_W-1:0]  ones_total;
    logic              win_done;
    logic              tf_det;
    logic              defect_det;
    logic              absorb;
    logic              chunk_full;
    logic [CRW-1:0]    need;
    logic              emit;
    logic [127:0]      s_abs;

    assign active   = (state_reg == hybrid_trng_pkg::ST_STARTUP) || (state_reg == hybrid_trng_pkg::ST_SEED) ||
                      (state_reg == hybrid_trng_pkg::ST_RUN);
    assign same_bit = (run_len_reg != '0) && (raw_bit_i == last_bit_reg);

    // total failure: stuck source or silent source
    assign tf_det = active && ((raw_valid_i && same_bit && (run_len_reg >= RUN_W'(TF_RUN - 1))) ||
                    (silence_reg >= SIL_W'(hybrid_trng_pkg::SILENCE_CYCLES - 1)));

    // proportion test, every raw bit counted
    assign ones_total = ones_reg + WIN_W'(raw_bit_i);
    assign win_done   = active && raw_valid_i && (win_cnt_reg == WIN_W'(hybrid_trng_pkg::WIN_LEN - 1));
    assign defect_det = win_done && ((ones_total < WIN_W'(hybrid_trng_pkg::ONES_LO)) ||
                        (ones_total > WIN_W'(hybrid_trng_pkg::ONES_HI)));

    // a bit is absorbed only after TF_RUN newer bits proved the source alive
    assign absorb = ((state_reg == hybrid_trng_pkg::ST_SEED) || (state_reg == hybrid_trng_pkg::ST_RUN)) &&
                    raw_valid_i && (fill_reg == DLW'(TF_RUN)) && !tf_det && !defect_det;
    assign chunk_full = absorb && (chunk_cnt_reg == CHW'(hybrid_trng_pkg::CHUNK_BITS - 1));

    assign need = width16_i ? CRW'(hybrid_trng_pkg::W16) : CRW'(hybrid_trng_pkg::W8);

    // valid only in run, with credit and no fresh failure or defect
    assign rnd_valid_o = (state_reg == hybrid_trng_pkg::ST_RUN) && (credit_reg >= need) &&
                         !tf_det && !defect_det;
    assign emit        = rnd_valid_o && rnd_ready_i;

    assign rnd_data_o   = width16_i ? out_word_reg : {8'h00, out_word_reg[7:0]};
    assign total_fail_o = (state_reg == hybrid_trng_pkg::ST_FAIL);
    assign defect_o     = (state_reg == hybrid_trng_pkg::ST_DEFECT);
    assign seeded_o     = (state_reg == hybrid_trng_pkg::ST_RUN);

    // controller
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            hybrid_trng_pkg::ST_IDLE, hybrid_trng_pkg::ST_DEFECT:
                if (start_i)
                    state_next = hybrid_trng_pkg::ST_STARTUP;
            hybrid_trng_pkg::ST_STARTUP:
                if (win_done && !defect_det)
                    state_next = hybrid_trng_pkg::ST_SEED;
            hybrid_trng_pkg::ST_SEED:
                if (seed_cnt_reg >= SEED_W'(SEED_BITS))
                    state_next = hybrid_trng_pkg::ST_RUN;
            hybrid_trng_pkg::ST_RUN:
                state_next = hybrid_trng_pkg::ST_RUN;
            hybrid_trng_pkg::ST_FAIL:
                state_next = hybrid_trng_pkg::ST_FAIL;
            default:
                state_next = hybrid_trng_pkg::ST_IDLE;
        endcase
        if (defect_det)
            state_next = hybrid_trng_pkg::ST_DEFECT;
        if (tf_det)
            state_next = hybrid_trng_pkg::ST_FAIL;
    end

    // health-test counters
    always_comb
    begin
        last_bit_next = last_bit_reg;
        run_len_next  = run_len_reg;
        silence_next  = silence_reg;
        win_cnt_next  = win_cnt_reg;
        ones_next     = ones_reg;
        delay_next    = delay_reg;
        fill_next     = fill_reg;
        if (!active)
        begin
            run_len_next = '0;
            silence_next = '0;
            win_cnt_next = '0;
            ones_next    = '0;
            fill_next    = '0;
        end
        else if (raw_valid_i)
        begin
            last_bit_next = raw_bit_i;
            run_len_next  = same_bit ? ((run_len_reg < RUN_W'(TF_RUN)) ? run_len_reg + RUN_W'(1) : run_len_reg)
                                     : RUN_W'(1);
            silence_next  = '0;
            delay_next    = {delay_reg[TF_RUN-2:0], raw_bit_i};
            fill_next     = (fill_reg < DLW'(TF_RUN)) ? fill_reg + DLW'(1) : fill_reg;
            if (win_done)
            begin
                win_cnt_next = '0;
                ones_next    = '0;
            end
            else
            begin
                win_cnt_next = win_cnt_reg + WIN_W'(1);
                ones_next    = ones_total;
            end
        end
        else if (silence_reg < SIL_W'(hybrid_trng_pkg::SILENCE_CYCLES))
            silence_next = silence_reg + SIL_W'(1);
    end

    // post-processor: absorb chunks, emit words against credit
    always_comb
    begin
        chunk_next     = chunk_reg;
        chunk_cnt_next = chunk_cnt_reg;
        seed_cnt_next  = seed_cnt_reg;
        credit_next    = credit_reg;
        s_abs          = pp_state_reg;
        if (!active)
        begin
            chunk_cnt_next = '0;
            seed_cnt_next  = '0;
            credit_next    = '0;
        end
        else if (absorb)
        begin
            chunk_next     = {chunk_reg[30:0], delay_reg[TF_RUN-1]};
            chunk_cnt_next = chunk_cnt_reg + CHW'(1);
            if (seed_cnt_reg < SEED_W'(SEED_BITS))
                seed_cnt_next = seed_cnt_reg + SEED_W'(1);
            if (credit_reg != {CRW{1'b1}})
                credit_next = credit_reg + CRW'(1);
            if (chunk_full)
                s_abs = qround(qround(pp_state_reg ^ {96'h0, chunk_next}));
        end
        if (emit)
            credit_next = credit_next - need;
        pp_state_next = emit ? qround(qround(s_abs ^ hybrid_trng_pkg::EMIT_TWEAK)) : s_abs;
        out_word_next = out_func(pp_state_next);
    end

    // controller state register
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_reg <= hybrid_trng_pkg::ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // health-test registers
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            last_bit_reg <= 1'b0;
            run_len_reg  <= '0;
            silence_reg  <= '0;
            win_cnt_reg  <= '0;
            ones_reg     <= '0;
            delay_reg    <= '0;
            fill_reg     <= '0;
        end
        else
        begin
            last_bit_reg <= last_bit_next;
            run_len_reg  <= run_len_next;
            silence_reg  <= silence_next;
            win_cnt_reg  <= win_cnt_next;
            ones_reg     <= ones_next;
            delay_reg    <= delay_next;
            fill_reg     <= fill_next;
        end
    end

    // post-processor registers
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            chunk_reg     <= '0;
            chunk_cnt_reg <= '0;
            seed_cnt_reg  <= '0;
            credit_reg    <= '0;
            pp_state_reg  <= hybrid_trng_pkg::STATE_INIT;
            out_word_reg  <= '0;
        end
        else
        begin
            chunk_reg     <= chunk_next;
            chunk_cnt_reg <= chunk_cnt_next;
            seed_cnt_reg  <= seed_cnt_next;
            credit_reg    <= credit_next;
            pp_state_reg  <= pp_state_next;
            out_word_reg  <= out_word_next;
        end
    end

endmodule : hybrid_physical_generator

// file: hybrid_physical_generator_assertions.sv
// checker for blocking, stickiness, word width and rate of the hybrid generator
// assumes it is bound to hybrid_physical_generator and sees only its ports
`timescale 1ns/1ns
module hybrid_physical_generator_checker #(
    parameter int TF_RUN = 32
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // observed ports
    input  wire logic        width16_i,
    input  wire logic        raw_bit_i,
    input  wire logic        raw_valid_i,
    input  wire logic [15:0] rnd_data_o,
    input  wire logic        rnd_valid_o,
    input  wire logic        rnd_ready_i,
    input  wire logic        total_fail_o,
    input  wire logic        defect_o,
    input  wire logic        seeded_o
);
    logic [31:0] in_bits_reg;
    logic [31:0] in_bits_next;
    logic [31:0] out_bits_reg;
    logic [31:0] out_bits_next;
    logic [15:0] quiet_reg;
    logic [15:0] quiet_next;

    always_comb
    begin
        in_bits_next  = in_bits_reg + {31'h0, raw_valid_i};
        out_bits_next = out_bits_reg;
        if (rnd_valid_o && rnd_ready_i)
            out_bits_next = out_bits_reg + (width16_i ? 32'h10 : 32'h8);
        quiet_next = (seeded_o && !raw_valid_i) ? quiet_reg + 16'h1 : 16'h0;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            in_bits_reg  <= 32'h0;
            out_bits_reg <= 32'h0;
            quiet_reg    <= 16'h0;
        end
        else
        begin
            in_bits_reg  <= in_bits_next;
            out_bits_reg <= out_bits_next;
            quiet_reg    <= quiet_next;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // stuck source: eight identical ones in a row
    sequence ones_run;
        (raw_valid_i && raw_bit_i) [*8];
    endsequence

    fail_blocks_a: assert property (total_fail_o |-> !rnd_valid_o)
        else $error("word offered after total failure");
    defect_blocks_a: assert property (defect_o |-> !rnd_valid_o)
        else $error("word offered during defect");
    valid_seeded_a: assert property (rnd_valid_o |-> seeded_o)
        else $error("word offered before seeding finished");
    fail_sticky_a: assert property (total_fail_o |=> total_fail_o)
        else $error("total failure flag cleared");
    byte_mode_a: assert property (rnd_valid_o && !width16_i |-> rnd_data_o[15:8] == 8'h00)
        else $error("upper byte not zero in byte mode");
    rate_bound_a: assert property (out_bits_reg <= in_bits_reg)
        else $error("more output bits than raw bits");
    silence_fail_a: assert property (quiet_reg <= 16'h3ED)
        else $error("silent source not flagged in time");
    stuck_run_a: assert property ((seeded_o && TF_RUN <= 4) ##0 ones_run |-> total_fail_o && !rnd_valid_o)
        else $error("stuck source not flagged");
    status_onehot_a: assert property ($onehot0({total_fail_o, defect_o, seeded_o}))
        else $error("status flags overlap");
endmodule : hybrid_physical_generator_checker

bind hybrid_physical_generator hybrid_physical_generator_checker #(.TF_RUN(TF_RUN)) u_hybrid_physical_generator_checker (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .width16_i(width16_i), .raw_bit_i(raw_bit_i), .raw_valid_i(raw_valid_i),
    .rnd_data_o(rnd_data_o), .rnd_valid_o(rnd_valid_o), .rnd_ready_i(rnd_ready_i), .total_fail_o(total_fail_o),
    .defect_o(defect_o), .seeded_o(seeded_o));

// file: word_consumer_model.sv
// consumer of random words: accepts at once or stalls every other cycle
// assumes the generator's valid/ready stream on clk_i
`timescale 1ns/1ns
module word_consumer_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // word stream
    input  wire logic        rnd_valid_i,
    output logic             rnd_ready_o,
    // control and count
    input  wire logic        slow_i,
    output logic [31:0]      words_o
);
    logic stall_reg;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            stall_reg <= 1'b0;
            words_o   <= 32'h0;
        end
        else
        begin
            stall_reg <= slow_i && !stall_reg;
            if (rnd_valid_i && rnd_ready_o)
                words_o <= words_o + 32'h1;
        end
    end

    assign rnd_ready_o = !stall_reg;
endmodule : word_consumer_model

// file: hybrid_physical_generator_tb_top.sv
// self-checking bench for the hybrid generator with short run and seed counts
// assumes the consumer model and the bound checker
`timescale 1ns/1ns
module hybrid_physical_generator_tb_top;
    localparam int TFR = 4;
    localparam int SB  = 32;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        start_i = 1'b0;
    logic        width16_i = 1'b0;
    logic        raw_bit_i = 1'b0;
    logic        raw_valid_i = 1'b0;
    logic        slow = 1'b0;
    logic [15:0] rnd_data_o;
    logic        rnd_valid_o;
    logic        rnd_ready_i;
    logic        total_fail_o;
    logic        defect_o;
    logic        seeded_o;
    logic [31:0] words;
    logic [31:0] fed = 32'h0;
    int          fails = 0;
    int          total_checks = 0;

    always #5 clk_i = ~clk_i;

    hybrid_physical_generator #(.TF_RUN(TFR), .SEED_BITS(SB)) u_hybrid_physical_generator (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .width16_i(width16_i), .raw_bit_i(raw_bit_i),
        .raw_valid_i(raw_valid_i), .rnd_data_o(rnd_data_o), .rnd_valid_o(rnd_valid_o), .rnd_ready_i(rnd_ready_i),
        .total_fail_o(total_fail_o), .defect_o(defect_o), .seeded_o(seeded_o));
    word_consumer_model u_word_consumer_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .rnd_valid_i(rnd_valid_o),
        .rnd_ready_o(rnd_ready_i), .slow_i(slow), .words_o(words));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    // pat 0 balanced, 1 one bit in four, 2 stuck at one, 3 source silent
    task automatic feed(input int n, input int pat);
        repeat (n)
        begin
            @(posedge clk_i);
            raw_valid_i <= (pat != 3);
            raw_bit_i   <= (pat == 0) ? fed[0] : (pat == 1) ? (fed[1:0] == 2'h3) : 1'b1;
            fed = fed + 32'h1;
        end
    endtask : feed

    task automatic do_reset;
        @(posedge clk_i);
        rst_b_i     <= 1'b0;
        raw_valid_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
    endtask : do_reset

    task automatic pulse_start;
        @(posedge clk_i);
        start_i     <= 1'b1;
        raw_valid_i <= 1'b0;
        @(posedge clk_i);
        start_i <= 1'b0;
    endtask : pulse_start

    task automatic t_start;
        // delay line fills during the window, so window plus seed bits reach run
        pulse_start();
        feed(64 + SB - 1, 0);
        #1 check("early seeded", seeded_o, 1'b0);
        check("early valid", rnd_valid_o, 1'b0);
        feed(1, 0);
        feed(1, 3);
        #1 check("seed done", seeded_o, 1'b0);
        feed(1, 3);
        #1 check("seeded", seeded_o, 1'b1);
    endtask : t_start

    task automatic t_words;
        logic [31:0] w0;
        w0 = words;
        feed(12, 3);
        #1 check("bytes from seed", words - w0, 32'h4);
        @(posedge clk_i);
        width16_i <= 1'b1;
        slow      <= 1'b1;
        feed(32, 0);
        feed(8, 3);
        #1 check("wide words", words - w0, 32'h6);
    endtask : t_words

    task automatic t_defect;
        feed(140, 1);
        #1 check("defect", defect_o, 1'b1);
        check("defect valid", rnd_valid_o, 1'b0);
    endtask : t_defect

    task automatic t_fail;
        feed(8, 2);
        #1 check("stuck fail", total_fail_o, 1'b1);
        pulse_start();
        feed(70, 0);
        #1 check("fail sticky", total_fail_o, 1'b1);
        check("fail seeded", seeded_o, 1'b0);
    endtask : t_fail

    task automatic t_silence;
        do_reset();
        pulse_start();
        feed(10, 0);
        feed(985, 3);
        #1 check("quiet early", total_fail_o, 1'b0);
        feed(25, 3);
        #1 check("quiet fail", total_fail_o, 1'b1);
    endtask : t_silence

    initial
    begin
        do_reset();
        t_start();
        t_words();
        t_defect();
        t_start();
        t_fail();
        t_silence();
        test_done();
    end

    initial
    begin
        #100000;
        fails++;
        test_done();
    end
endmodule : hybrid_physical_generator_tb_top
